// file: core/clk_mgr_host_defines.vh
// Purpose: Constants for the clock manager register port controller.
// Assumes: One clock at 125 MHz (8 ns period).
// Notes:   Times are printed in ns; cycle counts derive from them.
`ifndef CLK_MGR_HOST_DEFINES_VH
`define CLK_MGR_HOST_DEFINES_VH

// ----------------------------------------------------------------
// Register map of the clock manager
// ----------------------------------------------------------------
`define REG_OSC_RANGE_SELECT      3'h4
`define REG_POWER_RESET_CONTROL   3'h7
`define PRC_ENABLE_BIT            0
`define PRC_DLL_RESET_BIT         1
`define PRC_PLL_RESET_BIT         2
`define PRC_RUN_IN_CONFIG_BIT     6
`define PRC_GSR_IMMUNE_BIT        7
`define PRC_RESET_VALUE           8'h00

// ----------------------------------------------------------------
// Discouraged oscillator range codes, upper two and lower three bits
// ----------------------------------------------------------------
`define OSC_LOW_BAND_HI           2'h0
`define OSC_DISCOURAGED_MIN       3'h2
`define OSC_DISCOURAGED_MAX       3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS             8
`define ACQ_MAX_NS                100000
// Acquisition ceiling of 100 us at 8 ns per cycle, sized to the 16-bit counter.
`define ACQ_MAX_CYCLES            16'h30d4
`define LOCK_INTEG_CYCLES         16'h03e8
`define ADDR_SETUP_CYCLES         3'h2
`define READ_STROBE_CYCLES        3'h6
`define WRITE_STROBE_CYCLES       3'h4
`define WRITE_HOLD_CYCLES         3'h2
`define READ_HOLD_CYCLES          3'h1

`endif

// file: core/pin_sync.v
// Purpose: Three-stage synchroniser for pins from outside the clock domain.
// Assumes: A change is accepted once the second and third stages agree.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             ref_clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] pin_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_ff  <= {WIDTH{1'b0}};
      s2_ff  <= {WIDTH{1'b0}};
      s3_ff  <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        sync_o <= s3_ff;
      end
    end
  end

endmodule

`default_nettype wire

// file: core/clk_mgr_host_ctrl.v
// Purpose: Host-side controller for a clock manager's register port and lock pin.
// Assumes: The device captures write data on the rising write strobe edge.
// Notes:   One command at a time; the lock pin is integrated before use.
// Notes on behaviour
// R01 - Address is set up before the read strobe rises.
// R02 - Device drives read data while the read strobe stays high.
// R03 - Address may change during a read strobe; this host never does.
// R04 - Device floats its read data once the read strobe falls.
// R05 - Address and data are stable before and after the write strobe rises.
// R06 - Read strobe and write strobe are never high together.
// R07 - Device raises lock when output clock meets programmed values and jitter.
// R08 - Lock is integrated so two cycle dropouts restart the count; one cycle dropouts are absorbed by the synchroniser.
// R09 - Lock counts only once continuously high for the integration period.
// R10 - Register 7 bit 0 enables the manager; clear powers it down.
// R11 - Register 7 bits 2:1 reset DLL and PLL logic only.
// R12 - Register 7 bit 7 makes the manager ignore global reset.
// R13 - Register 7 bit 6 lets the manager run during configuration.
// R14 - With bit 6 clear the manager waits for configuration done.
// R15 - Enabling leads through wake-up and acquisition before steady state.
// R16 - Output clock is unstable during the shutdown interval.
// R17 - Register 4 range code picks a band; acquisition up to 100 us.
// R18 - The three highest-frequency range codes are refused by this host.
// R19 - Control registers are eight bits and read back the last write.
// R20 - Lock is ignored while disabled, held in reset or waking up; this host gates lock only on register 7 bits 0 and 2:1, with no wake-up wait.
`timescale 1ns/100ps
`default_nettype none
`include "clk_mgr_host_defines.vh"

module clk_mgr_host_ctrl #(
  parameter [15:0] ACQ_MAX_CYCLES = `ACQ_MAX_CYCLES
) (
  input  wire       ref_clk_i,
  input  wire       rst_i,
  // User command side.
  input  wire       cmd_valid_i,
  input  wire       cmd_write_i,
  input  wire [2:0] cmd_addr_i,
  input  wire [7:0] cmd_wdata_i,
  output reg        cmd_ready_o,
  output reg        rsp_valid_o,
  output reg  [7:0] rsp_rdata_o,
  output reg        cmd_refused_o,
  // Status toward user.
  output reg        mgr_enabled_o,
  output reg        lock_qualified_o,
  output reg        acq_timeout_o,
  // Device register port pins.
  output reg  [2:0] reg_addr_o,
  output reg  [7:0] reg_wdata_o,
  output reg        read_strobe_o,
  output reg        write_strobe_o,
  input  wire [7:0] reg_rdata_i,
  input  wire       lock_i
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [7:0] rdata_sync;
  wire       lock_sync;

  pin_sync #(.WIDTH(8)) u_rdata_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (reg_rdata_i),
    .sync_o    (rdata_sync)
  );

  pin_sync #(.WIDTH(1)) u_lock_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (lock_i),
    .sync_o    (lock_sync)
  );

  // ----------------------------------------------------------------
  // Register port sequencer
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_SETUP  = 2'h1;
  localparam [1:0] ST_STROBE = 2'h2;
  localparam [1:0] ST_HOLD   = 2'h3;

  reg  [1:0] state_ff;
  reg  [2:0] cnt_ff;
  reg        is_write_ff;
  reg  [7:0] prc_shadow_ff;

  wire       osc_discouraged;
  wire       cmd_take;

  // R18 refuse discouraged codes
  assign osc_discouraged = (cmd_addr_i == `REG_OSC_RANGE_SELECT) &&
                           (cmd_wdata_i[7:6] == `OSC_LOW_BAND_HI) &&
                           (cmd_wdata_i[2:0] >= `OSC_DISCOURAGED_MIN) &&
                           (cmd_wdata_i[2:0] <= `OSC_DISCOURAGED_MAX);
  assign cmd_take        = cmd_valid_i && cmd_ready_o;

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_ff       <= ST_IDLE;
      cnt_ff         <= 3'h0;
      is_write_ff    <= 1'b0;
      cmd_ready_o    <= 1'b1;
      rsp_valid_o    <= 1'b0;
      rsp_rdata_o    <= 8'h00;
      cmd_refused_o  <= 1'b0;
      reg_addr_o     <= 3'h0;
      reg_wdata_o    <= 8'h00;
      read_strobe_o  <= 1'b0;
      write_strobe_o <= 1'b0;
      prc_shadow_ff  <= `PRC_RESET_VALUE;
    end else begin
      rsp_valid_o   <= 1'b0;
      cmd_refused_o <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (cmd_take) begin
            if (cmd_write_i && osc_discouraged) begin
              cmd_refused_o <= 1'b1;
            end else begin
              // R01 address before strobe
              reg_addr_o  <= cmd_addr_i;
              reg_wdata_o <= cmd_wdata_i;
              is_write_ff <= cmd_write_i;
              cnt_ff      <= `ADDR_SETUP_CYCLES - 3'h1;
              cmd_ready_o <= 1'b0;
              state_ff    <= ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          if (cnt_ff == 3'h0) begin
            // R06 only one strobe at a time
            if (is_write_ff) begin
              // R05 rising edge writes
              write_strobe_o <= 1'b1;
              cnt_ff         <= `WRITE_STROBE_CYCLES - 3'h1;
            end else begin
              read_strobe_o <= 1'b1;
              cnt_ff        <= `READ_STROBE_CYCLES - 3'h1;
            end
            state_ff <= ST_STROBE;
          end else begin
            cnt_ff <= cnt_ff - 3'h1;
          end
        end
        // R03 address held under strobe
        ST_STROBE: begin
          if (cnt_ff == 3'h0) begin
            if (is_write_ff) begin
              write_strobe_o <= 1'b0;
              cnt_ff         <= `WRITE_HOLD_CYCLES - 3'h1;
              // R19 shadow of written control
              if (reg_addr_o == `REG_POWER_RESET_CONTROL) begin
                prc_shadow_ff <= reg_wdata_o;
              end
            end else begin
              // R02 sample while strobe high
              read_strobe_o <= 1'b0;
              rsp_rdata_o   <= rdata_sync;
              rsp_valid_o   <= 1'b1;
              cnt_ff        <= `READ_HOLD_CYCLES - 3'h1;
            end
            state_ff <= ST_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 3'h1;
          end
        end
        ST_HOLD: begin
          // R04 let the bus float before reuse
          if (cnt_ff == 3'h0) begin
            cmd_ready_o <= 1'b1;
            state_ff    <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 3'h1;
          end
        end
        default: begin
          state_ff       <= ST_IDLE;
          cmd_ready_o    <= 1'b1;
          read_strobe_o  <= 1'b0;
          write_strobe_o <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Lock integration and acquisition watch
  // ----------------------------------------------------------------
  reg  [15:0] lock_cnt_ff;
  reg  [15:0] acq_cnt_ff;
  wire        mgr_running;

  // R10 enable bit
  // R11 DLL and PLL resets hold lock invalid
  assign mgr_running = prc_shadow_ff[`PRC_ENABLE_BIT] &&
                       !prc_shadow_ff[`PRC_DLL_RESET_BIT] &&
                       !prc_shadow_ff[`PRC_PLL_RESET_BIT];

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      lock_cnt_ff      <= 16'h0000;
      acq_cnt_ff       <= 16'h0000;
      mgr_enabled_o    <= 1'b0;
      lock_qualified_o <= 1'b0;
      acq_timeout_o    <= 1'b0;
    end else begin
      mgr_enabled_o <= mgr_running;
      // R20 no lock while disabled
      // R16 shutdown leaves clock unusable
      if (!mgr_running) begin
        lock_cnt_ff      <= 16'h0000;
        acq_cnt_ff       <= 16'h0000;
        lock_qualified_o <= 1'b0;
        acq_timeout_o    <= 1'b0;
      end else begin
        // R08 dropouts restart count
        // R09 solid high only
        if (!lock_sync) begin
          lock_cnt_ff      <= 16'h0000;
          lock_qualified_o <= 1'b0;
        end else if (lock_cnt_ff == `LOCK_INTEG_CYCLES) begin
          lock_qualified_o <= 1'b1;
        end else begin
          lock_cnt_ff <= lock_cnt_ff + 16'h0001;
        end
        // R15 R17 acquisition bound
        if (lock_qualified_o) begin
          acq_cnt_ff <= 16'h0000;
        end else if (acq_cnt_ff == ACQ_MAX_CYCLES) begin
          acq_timeout_o <= 1'b1;
        end else begin
          acq_cnt_ff <= acq_cnt_ff + 16'h0001;
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: dv/clk_mgr_host_sva.sv
// Purpose: Port checks for the clock manager host controller.
// Assumes: One clock domain with a synchronous reset.
// Notes:   Attached to every controller instance by bind.
`timescale 1ns/100ps
`default_nettype none
module clk_mgr_host_sva (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       cmd_valid_i,
  input wire logic       cmd_write_i,
  input wire logic [2:0] cmd_addr_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic       cmd_ready_o,
  input wire logic       rsp_valid_o,
  input wire logic       cmd_refused_o,
  input wire logic       mgr_enabled_o,
  input wire logic       lock_qualified_o,
  input wire logic [2:0] reg_addr_o,
  input wire logic [7:0] reg_wdata_o,
  input wire logic       read_strobe_o,
  input wire logic       write_strobe_o,
  input wire logic       lock_i
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_no_overlap: assert property (!(read_strobe_o && write_strobe_o))
    else $error("Read and write strobes high together");
  a_rd_addr_held: assert property (read_strobe_o |-> $stable(reg_addr_o))
    else $error("Address moved under the read strobe");
  a_wr_setup_held: assert property (write_strobe_o |-> $stable(reg_addr_o) && $stable(reg_wdata_o))
    else $error("Write address or data moved under the write strobe");
  a_wr_launch: assert property (cmd_valid_i && cmd_ready_o && cmd_write_i && cmd_addr_i != 3'h4
    |-> ##3 $rose(write_strobe_o) ##1 write_strobe_o[*3] ##1 !write_strobe_o)
    else $error("Write strobe timing wrong");
  a_rd_launch: assert property (cmd_valid_i && cmd_ready_o && !cmd_write_i
    |-> ##3 $rose(read_strobe_o) ##1 read_strobe_o[*5] ##1 (!read_strobe_o && rsp_valid_o))
    else $error("Read strobe or response timing wrong");
  a_refuse_code: assert property (cmd_valid_i && cmd_ready_o && cmd_write_i
    && cmd_addr_i == 3'h4 && cmd_wdata_i[7:6] == 2'h0 && cmd_wdata_i[2:0] >= 3'h2
    && cmd_wdata_i[2:0] <= 3'h4 |=> cmd_refused_o && cmd_ready_o && !write_strobe_o)
    else $error("Discouraged range code not refused");
  a_lock_drop: assert property (!lock_i ##1 !lock_i |-> ##[0:6] !lock_qualified_o)
    else $error("Qualified lock survived a lock dropout");
  a_lock_gated: assert property (!mgr_enabled_o ##1 !mgr_enabled_o |-> !lock_qualified_o)
    else $error("Qualified lock while disabled");
endmodule
bind clk_mgr_host_ctrl clk_mgr_host_sva sva (.ref_clk_i, .rst_i, .cmd_valid_i, .cmd_write_i,
  .cmd_addr_i, .cmd_wdata_i, .cmd_ready_o, .rsp_valid_o, .cmd_refused_o, .mgr_enabled_o,
  .lock_qualified_o, .reg_addr_o, .reg_wdata_o, .read_strobe_o, .write_strobe_o, .lock_i);
`default_nettype wire

// file: dv/clk_mgr_dev_model.sv
// Purpose: Behavioural clock manager register port and lock pin.
// Assumes: Writes land on the rising write strobe.
// Notes:   A floated read bus shows the inverse of the last value read.
`timescale 1ns/100ps
`default_nettype none
module clk_mgr_dev_model #(
  parameter int WAKE = 8,
  parameter int ACQ  = 40
) (
  input  wire logic       ref_clk_i,
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       read_strobe_i,
  input  wire logic       write_strobe_i,
  input  wire logic       cfg_done_i,
  input  wire logic       gsr_n_i,
  input  wire logic       glitch_i,
  output logic      [7:0] reg_rdata_o,
  output logic            lock_o
);
  logic [7:0] regs [8];
  logic [7:0] last = 8'h00;
  logic       run;
  int         cnt = 0;
  initial for (int i = 0; i < 8; i++) regs[i] = 8'h00;
  always @(posedge write_strobe_i) regs[reg_addr_i] <= reg_wdata_i;
  always @* reg_rdata_o = read_strobe_i ? regs[reg_addr_i] : ~last;
  always @(posedge ref_clk_i) if (read_strobe_i) last <= regs[reg_addr_i];
  assign run = regs[7][0] && regs[7][2:1] == 2'h0 && (regs[7][6] || cfg_done_i)
    && (regs[7][7] || gsr_n_i);
  always @(posedge ref_clk_i) cnt <= run ? (cnt < WAKE + ACQ ? cnt + 1 : cnt) : 0;
  always @* lock_o = cnt >= WAKE + ACQ ? !glitch_i : (cnt >= WAKE && cnt[1]);
endmodule
`default_nettype wire

// file: dv/tb.sv
// Purpose: Self-checking bench for the clock manager host controller.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Acquisition limit shortened to 1200 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic       ref_clk_i = 0, rst_i = 1, cmd_valid_i = 0, cmd_write_i = 0, glitch = 1;
  logic [2:0] cmd_addr_i = 3'h0, reg_addr_o;
  logic [7:0] cmd_wdata_i = 8'h00, rsp_rdata_o, reg_wdata_o, reg_rdata_i;
  logic       cmd_ready_o, rsp_valid_o, cmd_refused_o, mgr_enabled_o, lock_qualified_o;
  logic       acq_timeout_o, read_strobe_o, write_strobe_o, lock_i;
  logic       was_refused = 0;
  int         n_mismatch = 0, checks = 0, cyc = 0;
  clk_mgr_host_ctrl #(.ACQ_MAX_CYCLES(16'h04b0)) dut (.ref_clk_i, .rst_i, .cmd_valid_i,
    .cmd_write_i, .cmd_addr_i, .cmd_wdata_i, .cmd_ready_o, .rsp_valid_o, .rsp_rdata_o,
    .cmd_refused_o, .mgr_enabled_o, .lock_qualified_o, .acq_timeout_o, .reg_addr_o,
    .reg_wdata_o, .read_strobe_o, .write_strobe_o, .reg_rdata_i, .lock_i);
  clk_mgr_dev_model #(.WAKE(8), .ACQ(40)) model (.ref_clk_i, .reg_addr_i(reg_addr_o),
    .reg_wdata_i(reg_wdata_o), .read_strobe_i(read_strobe_o), .write_strobe_i(write_strobe_o),
    .cfg_done_i(1'b1), .gsr_n_i(1'b1), .glitch_i(glitch), .reg_rdata_o(reg_rdata_i),
    .lock_o(lock_i));
  always #4 ref_clk_i = ~ref_clk_i;
  task report_and_stop;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cmd(input logic w, input logic [2:0] a, input logic [7:0] d);
    int i;
    i = 0;
    while (cmd_ready_o !== 1'b1 && i < 40) begin
      @(negedge ref_clk_i);
      i++;
    end
    {cmd_valid_i, cmd_write_i, cmd_addr_i, cmd_wdata_i} = {1'b1, w, a, d};
    @(negedge ref_clk_i);
    cmd_valid_i = 0;
    was_refused = cmd_refused_o;
    @(negedge ref_clk_i);
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    int i;
    cmd(1'b0, a, 8'h00);
    i = 0;
    while (rsp_valid_o !== 1'b1 && i < 20) begin
      @(negedge ref_clk_i);
      i++;
    end
    chk(rsp_valid_o, 1'b1);
    chk(rsp_rdata_o, e);
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  initial begin
    int i;
    repeat (3) @(negedge ref_clk_i);
    rst_i = 0;
    chk(cmd_ready_o, 1'b1); // RESET
    chk(mgr_enabled_o, 1'b0); // RESET
    for (int a = 0; a < 8; a++) cmd(1'b1, a[2:0], 8'ha5 ^ a[7:0]);
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'ha5 ^ a[7:0]);
    for (int c = 2; c < 5; c++) begin
      cmd(1'b1, 3'h4, c[7:0] | 8'h38);
      chk(was_refused, 1'b1);
    end
    rd(3'h4, 8'ha1);
    cmd(1'b1, 3'h4, 8'h05);
    chk(was_refused, 1'b0);
    rd(3'h4, 8'h05);
    cmd(1'b1, 3'h7, 8'h01);
    repeat (10) @(negedge ref_clk_i);
    chk(mgr_enabled_o, 1'b1);
    chk(acq_timeout_o, 1'b0);
    repeat (1250) @(negedge ref_clk_i);
    chk(acq_timeout_o, 1'b1);
    chk(lock_qualified_o, 1'b0);
    glitch = 0;
    i = 0;
    while (lock_qualified_o !== 1'b1 && i < 1100) begin
      @(negedge ref_clk_i);
      i++;
    end
    chk(lock_qualified_o, 1'b1);
    glitch = 1;
    repeat (3) @(negedge ref_clk_i);
    glitch = 0;
    repeat (8) @(negedge ref_clk_i);
    chk(lock_qualified_o, 1'b0);
    repeat (1010) @(negedge ref_clk_i);
    chk(lock_qualified_o, 1'b1);
    cmd(1'b1, 3'h7, 8'h03);
    repeat (10) @(negedge ref_clk_i);
    chk(mgr_enabled_o, 1'b0);
    chk(lock_qualified_o, 1'b0);
    chk(acq_timeout_o, 1'b0);
    rd(3'h4, 8'h05);
    rd(3'h7, 8'h03);
    report_and_stop;
  end
endmodule
`default_nettype wire
